// >>> dv/pcrb_tb.sv
// self-checking testbench for the peripheral control register bank
`timescale 1ns/100ps
module tb import pcrb_pkg::*;;
	typedef struct {logic [PCRB_AW-1:0] a; logic [PCRB_DW-1:0] d; logic [PCRB_DW-1:0] e;} pcrb_row_t;
	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [PCRB_AW-1:0] reg_addr_in = '0;
	logic [PCRB_DW-1:0] reg_wdata_in = '0;
	logic reg_write_in = 1'b0;
	logic reg_read_in = 1'b0;
	logic [PCRB_DW-1:0] reg_rdata_out;
	logic instr_tick_in = 1'b1;
	logic port6_bit3_pin_in = 1'b0;
	logic third_count_tick_out, third_pin_is_gpio_out;
	logic mod_wave_in = 1'b0;
	logic carrier_mode_out, pwm_mode_out, high_time_used_out, modulated_output_pin_out, port6_bit7_mod_sel_out;
	logic [PCRB_DW-1:0] port5_pulldown_n_out, port6_opendrain_n_out, port5_pullup_n_out;
	logic wdt_base_tick_in = 1'b1;
	logic watchdog_on_out, wdt_tick_out;
	logic port6_bit0_pin_in = 1'b1;
	logic [PCRB_DW-1:0] irq_flag_in = '0;
	logic irq_conv_done_in = 1'b0;
	logic irq_compare_change_in = 1'b0;
	logic global_irq_on_instr_in = 1'b0;
	logic global_irq_off_instr_in = 1'b0;
	logic ext_irq_pin_sel_out, ext_irq_level_out, irq_req_out;
	int fails = 0;
	int comparisons = 0;
	logic [15:0] tc = '0;
	logic [15:0] wc = '0;
	pcrb_row_t rows [9];

	pcrb_bank DUT (
		.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
		.reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
		.instr_tick_in(instr_tick_in), .port6_bit3_pin_in(port6_bit3_pin_in),
		.third_count_tick_out(third_count_tick_out), .third_pin_is_gpio_out(third_pin_is_gpio_out),
		.mod_wave_in(mod_wave_in), .carrier_mode_out(carrier_mode_out), .pwm_mode_out(pwm_mode_out),
		.high_time_used_out(high_time_used_out), .modulated_output_pin_out(modulated_output_pin_out),
		.port6_bit7_mod_sel_out(port6_bit7_mod_sel_out), .port5_pulldown_n_out(port5_pulldown_n_out),
		.port6_opendrain_n_out(port6_opendrain_n_out), .port5_pullup_n_out(port5_pullup_n_out),
		.wdt_base_tick_in(wdt_base_tick_in), .watchdog_on_out(watchdog_on_out), .wdt_tick_out(wdt_tick_out),
		.port6_bit0_pin_in(port6_bit0_pin_in), .irq_flag_in(irq_flag_in), .irq_conv_done_in(irq_conv_done_in),
		.irq_compare_change_in(irq_compare_change_in), .global_irq_on_instr_in(global_irq_on_instr_in),
		.global_irq_off_instr_in(global_irq_off_instr_in), .ext_irq_pin_sel_out(ext_irq_pin_sel_out),
		.ext_irq_level_out(ext_irq_level_out), .irq_req_out(irq_req_out)
	);

	always #2 clk_sys_in = ~clk_sys_in;
	// free-running tick counters; scenarios take differences so no second driver is needed
	always @(posedge clk_sys_in) begin
		if (third_count_tick_out === 1'b1) tc <= tc + 16'h0001;
		if (wdt_tick_out === 1'b1) wc <= wc + 16'h0001;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [PCRB_AW-1:0] a, input logic [PCRB_DW-1:0] d);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_write_in <= 1'b0;
	endtask
	task automatic rd(input logic [PCRB_AW-1:0] a, output logic [PCRB_DW-1:0] d);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_read_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask
	task automatic rd_chk(input logic [PCRB_AW-1:0] a, input logic [PCRB_DW-1:0] e);
		logic [PCRB_DW-1:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	task automatic settle();
		repeat (2) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic pulse(input logic on);
		@(posedge clk_sys_in);
		if (on) global_irq_on_instr_in <= 1'b1; else global_irq_off_instr_in <= 1'b1;
		@(posedge clk_sys_in);
		global_irq_on_instr_in <= 1'b0;
		global_irq_off_instr_in <= 1'b0;
		settle();
	endtask
	task automatic reset_check();
		@(posedge clk_sys_in);
		rst_b_in <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		@(posedge clk_sys_in);
		#1;
		chk({modulated_output_pin_out, ext_irq_level_out, third_pin_is_gpio_out, high_time_used_out, irq_req_out},
			16'h001E);
		chk({port5_pulldown_n_out, port6_opendrain_n_out}, 16'h0000);
		chk({port5_pullup_n_out, watchdog_on_out}, 16'h0000);
		foreach (rows[i]) rd_chk(rows[i].a, 8'h00);
		$display("test reset done");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		fails++;
		wrap_up();
	end
	initial begin
		logic [15:0] t0, w0, e;
		rows = '{'{OFS_AUX_BC, 8'hFF, 8'hF7}, '{OFS_IR_SCALE, 8'hA5, 8'hA5}, '{OFS_PULLDOWN, 8'h5A, 8'h5A},
			'{OFS_OPENDRAIN, 8'hC3, 8'hC3}, '{OFS_PULLUP, 8'h3C, 8'h3C}, '{OFS_WDT_MASK2, 8'h96, 8'h96},
			'{OFS_IRQ_MASK, 8'h69, 8'h69}, '{OFS_GLOBAL, 8'hFF, 8'h00}, '{4'hA, 8'hFF, 8'h00}};
		reset_check();
		foreach (rows[i]) wr(rows[i].a, rows[i].d);
		foreach (rows[i]) rd_chk(rows[i].a, rows[i].e);
		chk({port5_pulldown_n_out, port6_opendrain_n_out}, 16'h5AC3);
		chk(port5_pullup_n_out, 16'h003C);
		$display("test register table done");
		// -2 disabled, -1 scaler bypassed, 0..7 scale codes; scalers cleared by disabling first
		for (int c = -2; c < 8; c++) begin
			wr(OFS_AUX_BC, 8'h00);
			wr(OFS_WDT_MASK2, 8'h00);
			wr(OFS_IR_SCALE, (c < 0) ? 8'h00 : {1'b1, c[2:0], 4'h0});
			wr(OFS_WDT_MASK2, (c == -2) ? 8'h00 : (c == -1) ? 8'h80 : {5'b10001, c[2:0]});
			if (c > -2) wr(OFS_AUX_BC, 8'h04);
			repeat (4) @(posedge clk_sys_in);
			t0 = tc;
			w0 = wc;
			repeat (256) @(posedge clk_sys_in);
			e = (c == -2) ? 16'h0000 : (16'h0100 >> (c + 1));
			chk(tc - t0, e);
			chk(wc - w0, e);
			chk(third_pin_is_gpio_out, 16'h0001);
		end
		$display("test scalers done");
		// instruction ticks stay on, so any count here proves the pin alone drives the counter
		wr(OFS_IR_SCALE, 8'h00);
		for (int e2 = 0; e2 < 2; e2++) begin
			port6_bit3_pin_in <= 1'b0;
			wr(OFS_AUX_BC, {7'b0000_011, e2[0]});
			repeat (4) @(posedge clk_sys_in);
			chk(third_pin_is_gpio_out, 16'h0000);
			t0 = tc;
			port6_bit3_pin_in <= 1'b1;
			repeat (4) @(posedge clk_sys_in);
			chk(tc - t0, (e2 == 0) ? 16'h0001 : 16'h0000);
			t0 = tc;
			port6_bit3_pin_in <= 1'b0;
			repeat (4) @(posedge clk_sys_in);
			chk(tc - t0, (e2 == 1) ? 16'h0001 : 16'h0000);
		end
		$display("test pin source done");
		for (int v = 0; v < 16; v++) begin
			wr(OFS_IR_SCALE, {4'h0, v[3:0]});
			// wave input toggles so the pass-through shows while the modulator is on
			mod_wave_in <= v[0];
			settle();
			chk({carrier_mode_out, pwm_mode_out, high_time_used_out, port6_bit7_mod_sel_out, modulated_output_pin_out},
				{v[3] & v[2], v[3] & ~v[2], ~v[1], v[0], ~v[3] | v[0]});
		end
		$display("test modulator done");
		@(posedge clk_sys_in);
		irq_flag_in <= 8'h3C;
		wr(OFS_IRQ_MASK, 8'hA5);
		rd_chk(OFS_IRQ_FLAG, 8'h24);
		settle();
		chk(irq_req_out, 16'h0000);
		pulse(1'b1);
		rd_chk(OFS_GLOBAL, 8'h01);
		chk(irq_req_out, 16'h0001);
		for (int i = 0; i < 8; i++) begin
			wr(OFS_IRQ_MASK, 8'h01 << i);
			irq_flag_in <= ~(8'h01 << i);
			settle();
			chk(irq_req_out, 16'h0000);
			@(posedge clk_sys_in);
			irq_flag_in <= 8'h01 << i;
			settle();
			chk(irq_req_out, 16'h0001);
		end
		wr(OFS_IRQ_MASK, 8'h00);
		irq_conv_done_in <= 1'b1;
		wr(OFS_WDT_MASK2, 8'h20);
		settle();
		chk(irq_req_out, 16'h0001);
		rd_chk(OFS_IRQ_FLAG2, 8'h20);
		wr(OFS_WDT_MASK2, 8'h10);
		settle();
		chk(irq_req_out, 16'h0000);
		@(posedge clk_sys_in);
		irq_compare_change_in <= 1'b1;
		settle();
		chk(irq_req_out, 16'h0001);
		pulse(1'b0);
		chk(irq_req_out, 16'h0000);
		@(posedge clk_sys_in);
		port6_bit0_pin_in <= 1'b0;
		wr(OFS_WDT_MASK2, 8'h40);
		settle();
		chk({ext_irq_pin_sel_out, ext_irq_level_out}, 16'h0002);
		wr(OFS_WDT_MASK2, 8'h00);
		settle();
		chk({ext_irq_pin_sel_out, ext_irq_level_out}, 16'h0001);
		$display("test interrupts done");
		wr(OFS_PULLUP, 8'hFF);
		reset_check();
		wrap_up();
	end
endmodule

// >>> verilog/pcrb_bank.sv
// peripheral control register bank: timer, modulator, pin, watchdog and interrupt-mask control
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////
module pcrb_bank
	import pcrb_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// register port
	input wire logic [PCRB_AW-1:0] reg_addr_in,
	input wire logic [PCRB_DW-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [PCRB_DW-1:0] reg_rdata_out,
	// third counter sources
	input wire logic instr_tick_in,
	input wire logic port6_bit3_pin_in,
	output logic third_count_tick_out,
	output logic third_pin_is_gpio_out,
	// modulator
	input wire logic mod_wave_in,
	output logic carrier_mode_out,
	output logic pwm_mode_out,
	output logic high_time_used_out,
	output logic modulated_output_pin_out,
	output logic port6_bit7_mod_sel_out,
	// pad options
	output logic [PCRB_DW-1:0] port5_pulldown_n_out,
	output logic [PCRB_DW-1:0] port6_opendrain_n_out,
	output logic [PCRB_DW-1:0] port5_pullup_n_out,
	// watchdog
	input wire logic wdt_base_tick_in,
	output logic watchdog_on_out,
	output logic wdt_tick_out,
	// interrupts
	input wire logic port6_bit0_pin_in,
	input wire logic [PCRB_DW-1:0] irq_flag_in,
	input wire logic irq_conv_done_in,
	input wire logic irq_compare_change_in,
	input wire logic global_irq_on_instr_in,
	input wire logic global_irq_off_instr_in,
	output logic ext_irq_pin_sel_out,
	output logic ext_irq_level_out,
	output logic irq_req_out
);

	typedef struct packed {
		logic [PCRB_DW-1:0] aux_bc;
		logic [PCRB_DW-1:0] ir_scale;
		logic [PCRB_DW-1:0] pulldown_n;
		logic [PCRB_DW-1:0] opendrain_n;
		logic [PCRB_DW-1:0] pullup_n;
		logic [PCRB_DW-1:0] wdt_mask2;
		logic [PCRB_DW-1:0] irq_mask;
		logic gie;
		logic [PCRB_DW-1:0] rdata;
		logic pin3_prev;
		logic [PCRB_DW-1:0] third_cnt;
		logic third_tick;
		logic [PCRB_DW-1:0] wdt_cnt;
		logic wdt_tick;
		logic mod_pin;
		logic ext_level;
		logic irq_req;
		logic gpio_pin;
		logic carrier_on;
		logic pwm_on;
		logic high_used;
	} pcrb_state_t;

	pcrb_state_t st_r;
	pcrb_state_t st_nxt;

	logic third_src;
	logic third_edge;
	logic [PCRB_DW-1:0] third_last;
	logic [PCRB_DW-1:0] wdt_last;
	logic [1:0] flag2_masked;
	logic [PCRB_DW-1:0] flag_masked;

	//////////////////////////////////////////////////////////////////////////////////////
	// combinational next state
	always_comb begin
		st_nxt = st_r;
		third_last = scale_last(st_r.ir_scale[B_THIRD_SCL_HI:B_THIRD_SCL_LO]);
		wdt_last = scale_last(st_r.wdt_mask2[B_WDT_RATIO_HI:B_WDT_RATIO_LO]);
		flag_masked = irq_flag_in & st_r.irq_mask;
		flag2_masked = {irq_conv_done_in & st_r.wdt_mask2[B_CONV_MASK],
			irq_compare_change_in & st_r.wdt_mask2[B_CMP_MASK]};

		// register writes; unmapped and read-only offsets ignore writes
		if (reg_write_in) begin
			case (reg_addr_in)
				OFS_AUX_BC: st_nxt.aux_bc = reg_wdata_in & AUX_BC_WMASK;
				OFS_IR_SCALE: st_nxt.ir_scale = reg_wdata_in;
				OFS_PULLDOWN: st_nxt.pulldown_n = reg_wdata_in;
				OFS_OPENDRAIN: st_nxt.opendrain_n = reg_wdata_in;
				OFS_PULLUP: st_nxt.pullup_n = reg_wdata_in;
				OFS_WDT_MASK2: st_nxt.wdt_mask2 = reg_wdata_in;
				OFS_IRQ_MASK: st_nxt.irq_mask = reg_wdata_in;
				default: begin
				end
			endcase
		end

		// read data stands for exactly the cycle after the read strobe
		st_nxt.rdata = REG_RESET;
		if (reg_read_in) begin
			case (reg_addr_in)
				OFS_AUX_BC: st_nxt.rdata = st_r.aux_bc;
				OFS_IR_SCALE: st_nxt.rdata = st_r.ir_scale;
				OFS_PULLDOWN: st_nxt.rdata = st_r.pulldown_n;
				OFS_OPENDRAIN: st_nxt.rdata = st_r.opendrain_n;
				OFS_PULLUP: st_nxt.rdata = st_r.pullup_n;
				OFS_WDT_MASK2: st_nxt.rdata = st_r.wdt_mask2;
				OFS_IRQ_MASK: st_nxt.rdata = st_r.irq_mask;
				OFS_IRQ_FLAG: st_nxt.rdata = flag_masked;
				OFS_IRQ_FLAG2: st_nxt.rdata = {2'b00, flag2_masked, 4'h0};
				OFS_GLOBAL: st_nxt.rdata = {7'h00, st_r.gie};
				default: st_nxt.rdata = REG_RESET;
			endcase
		end

		// third counter tick: source, edge, enable, scaler
		st_nxt.pin3_prev = port6_bit3_pin_in;
		third_edge = st_r.aux_bc[B_THIRD_EDGE] ? (st_r.pin3_prev & ~port6_bit3_pin_in)
			: (~st_r.pin3_prev & port6_bit3_pin_in);
		third_src = st_r.aux_bc[B_THIRD_SRC] ? third_edge : instr_tick_in;
		st_nxt.third_tick = 1'b0;
		if (!st_r.aux_bc[B_THIRD_ON]) begin
			st_nxt.third_cnt = REG_RESET;
		end else if (third_src) begin
			if (!st_r.ir_scale[B_THIRD_SCL_ON]) begin
				st_nxt.third_tick = 1'b1;
				st_nxt.third_cnt = REG_RESET;
			end else if (st_r.third_cnt >= third_last) begin
				st_nxt.third_tick = 1'b1;
				st_nxt.third_cnt = REG_RESET;
			end else begin
				st_nxt.third_cnt = st_r.third_cnt + CNT_ONE;
			end
		end

		// watchdog prescaler
		st_nxt.wdt_tick = 1'b0;
		if (!st_r.wdt_mask2[B_WDT_ON]) begin
			st_nxt.wdt_cnt = REG_RESET;
		end else if (wdt_base_tick_in) begin
			if (!st_r.wdt_mask2[B_WDT_PRESCALE]) begin
				st_nxt.wdt_tick = 1'b1;
				st_nxt.wdt_cnt = REG_RESET;
			end else if (st_r.wdt_cnt >= wdt_last) begin
				st_nxt.wdt_tick = 1'b1;
				st_nxt.wdt_cnt = REG_RESET;
			end else begin
				st_nxt.wdt_cnt = st_r.wdt_cnt + CNT_ONE;
			end
		end

		// modulated output idles high while the modulator is off
		st_nxt.mod_pin = st_r.ir_scale[B_MOD_ON] ? mod_wave_in : 1'b1;

		// external interrupt pin; idle high when the path is masked
		st_nxt.ext_level = st_r.wdt_mask2[B_EXT_SEL] ? port6_bit0_pin_in : 1'b1;

		// global enable: enable wins if both instructions coincide
		if (global_irq_on_instr_in) begin
			st_nxt.gie = 1'b1;
		end else if (global_irq_off_instr_in) begin
			st_nxt.gie = 1'b0;
		end
		st_nxt.irq_req = st_r.gie & ((|flag_masked) | (|flag2_masked));

		// decoded levels are registered from the new register value, so they change with the write
		st_nxt.gpio_pin = ~st_nxt.aux_bc[B_THIRD_SRC];
		st_nxt.carrier_on = st_nxt.ir_scale[B_MOD_ON] & st_nxt.ir_scale[B_CARRIER];
		st_nxt.pwm_on = st_nxt.ir_scale[B_MOD_ON] & ~st_nxt.ir_scale[B_CARRIER];
		st_nxt.high_used = ~st_nxt.ir_scale[B_LONG_PULSE];
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			st_r <= '0;
			st_r.mod_pin <= 1'b1;
			st_r.ext_level <= 1'b1;
			st_r.gpio_pin <= 1'b1;
			st_r.high_used <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops
	assign reg_rdata_out = st_r.rdata;
	assign third_count_tick_out = st_r.third_tick;
	assign third_pin_is_gpio_out = st_r.gpio_pin;
	// carrier only when modulator and carrier mode are both on
	assign carrier_mode_out = st_r.carrier_on;
	assign pwm_mode_out = st_r.pwm_on;
	assign high_time_used_out = st_r.high_used;
	assign modulated_output_pin_out = st_r.mod_pin;
	// the pin only drives if software also made it an output
	assign port6_bit7_mod_sel_out = st_r.ir_scale[B_PIN_FUNC];
	assign port5_pulldown_n_out = st_r.pulldown_n;
	assign port6_opendrain_n_out = st_r.opendrain_n;
	assign port5_pullup_n_out = st_r.pullup_n;
	assign watchdog_on_out = st_r.wdt_mask2[B_WDT_ON];
	assign wdt_tick_out = st_r.wdt_tick;
	assign ext_irq_pin_sel_out = st_r.wdt_mask2[B_EXT_SEL];
	assign ext_irq_level_out = st_r.ext_level;
	assign irq_req_out = st_r.irq_req;

	//////////////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	property p_third_off;
		!st_r.aux_bc[B_THIRD_ON] |=> !third_count_tick_out && st_r.third_cnt == REG_RESET;
	endproperty
	a_third_off: assert property (p_third_off) else $error("third counter ticked while off");

	property p_third_edge;
		st_r.aux_bc[B_THIRD_ON] && st_r.aux_bc[B_THIRD_SRC] && !st_r.ir_scale[B_THIRD_SCL_ON]
			&& ($past(port6_bit3_pin_in) != port6_bit3_pin_in)
			&& (port6_bit3_pin_in == !st_r.aux_bc[B_THIRD_EDGE])
		|=> third_count_tick_out;
	endproperty
	a_third_edge: assert property (p_third_edge) else $error("selected pin edge not counted");

	property p_third_internal;
		st_r.aux_bc[B_THIRD_ON] && !st_r.aux_bc[B_THIRD_SRC] && !st_r.ir_scale[B_THIRD_SCL_ON]
		|=> third_count_tick_out == $past(instr_tick_in);
	endproperty
	a_third_internal: assert property (p_third_internal) else $error("unscaled tick wrong");

	property p_third_scale;
		third_count_tick_out && $past(st_r.ir_scale[B_THIRD_SCL_ON])
		|-> $past(st_r.third_cnt) == scale_last($past(st_r.ir_scale[B_THIRD_SCL_HI:B_THIRD_SCL_LO]));
	endproperty
	a_third_scale: assert property (p_third_scale) else $error("scaler wrapped early");

	property p_mod_idle;
		!st_r.ir_scale[B_MOD_ON] |=> modulated_output_pin_out;
	endproperty
	a_mod_idle: assert property (p_mod_idle) else $error("modulated pin not high");

	property p_pad_write;
		reg_write_in && reg_addr_in == OFS_PULLDOWN |=> port5_pulldown_n_out == $past(reg_wdata_in);
	endproperty
	a_pad_write: assert property (p_pad_write) else $error("pull-down write lost");

	property p_wdt_off;
		!watchdog_on_out |=> !wdt_tick_out;
	endproperty
	a_wdt_off: assert property (p_wdt_off) else $error("watchdog ticked while off");

	property p_wdt_1to1;
		watchdog_on_out && !st_r.wdt_mask2[B_WDT_PRESCALE] |=> wdt_tick_out == $past(wdt_base_tick_in);
	endproperty
	a_wdt_1to1: assert property (p_wdt_1to1) else $error("watchdog 1:1 wrong");

	property p_ext_masked;
		!ext_irq_pin_sel_out |=> ext_irq_level_out;
	endproperty
	a_ext_masked: assert property (p_ext_masked) else $error("external path not masked");

	property p_gie;
		!st_r.gie |=> !irq_req_out;
	endproperty
	a_gie: assert property (p_gie) else $error("request without global enable");

	property p_flag_read;
		reg_read_in && reg_addr_in == OFS_IRQ_FLAG |=> reg_rdata_out == $past(irq_flag_in & st_r.irq_mask);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read not masked");

	property p_mask_gate;
		st_r.gie && irq_flag_in != 8'h00 && st_r.irq_mask == 8'h00 && !irq_conv_done_in
			&& !irq_compare_change_in |=> !irq_req_out;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("masked source interrupted");

	property p_opendrain_write;
		reg_write_in && reg_addr_in == OFS_OPENDRAIN |=> port6_opendrain_n_out == $past(reg_wdata_in);
	endproperty
	a_opendrain_write: assert property (p_opendrain_write) else $error("open-drain write lost");

	property p_pullup_write;
		reg_write_in && reg_addr_in == OFS_PULLUP |=> port5_pullup_n_out == $past(reg_wdata_in);
	endproperty
	a_pullup_write: assert property (p_pullup_write) else $error("pull-up write lost");

	property p_gpio_src;
		reg_write_in && reg_addr_in == OFS_AUX_BC |=> third_pin_is_gpio_out == !$past(reg_wdata_in[B_THIRD_SRC]);
	endproperty
	a_gpio_src: assert property (p_gpio_src) else $error("pin role does not follow source");

	property p_carrier;
		reg_write_in && reg_addr_in == OFS_IR_SCALE
		|=> carrier_mode_out == ($past(reg_wdata_in[B_MOD_ON]) && $past(reg_wdata_in[B_CARRIER]));
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier mode wrong");

	property p_pwm;
		reg_write_in && reg_addr_in == OFS_IR_SCALE
		|=> pwm_mode_out == ($past(reg_wdata_in[B_MOD_ON]) && !$past(reg_wdata_in[B_CARRIER]));
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm mode wrong");

	property p_long_pulse;
		reg_write_in && reg_addr_in == OFS_IR_SCALE
		|=> high_time_used_out == !$past(reg_wdata_in[B_LONG_PULSE]);
	endproperty
	a_long_pulse: assert property (p_long_pulse) else $error("long pulse select wrong");

	property p_pin_func;
		reg_write_in && reg_addr_in == OFS_IR_SCALE
		|=> port6_bit7_mod_sel_out == $past(reg_wdata_in[B_PIN_FUNC]);
	endproperty
	a_pin_func: assert property (p_pin_func) else $error("pin function select wrong");

	property p_wdt_enable;
		reg_write_in && reg_addr_in == OFS_WDT_MASK2 |=> watchdog_on_out == $past(reg_wdata_in[B_WDT_ON]);
	endproperty
	a_wdt_enable: assert property (p_wdt_enable) else $error("watchdog enable lost");

	property p_wdt_scale;
		wdt_tick_out && $past(st_r.wdt_mask2[B_WDT_PRESCALE])
		|-> $past(st_r.wdt_cnt) == scale_last($past(st_r.wdt_mask2[B_WDT_RATIO_HI:B_WDT_RATIO_LO]));
	endproperty
	a_wdt_scale: assert property (p_wdt_scale) else $error("watchdog prescaler wrapped early");

	property p_conv_mask;
		st_r.gie && irq_conv_done_in && st_r.wdt_mask2[B_CONV_MASK] |=> irq_req_out;
	endproperty
	a_conv_mask: assert property (p_conv_mask) else $error("enabled converter request lost");

	// checked through reset itself, so the default disable is overridden here
	property p_reset_clear;
		disable iff (1'b0)
		!rst_b_in |=> st_r.aux_bc == REG_RESET && st_r.irq_mask == REG_RESET && !irq_req_out
			&& modulated_output_pin_out && third_pin_is_gpio_out;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("bank not cleared by reset");

	c_third_scaled: cover property (st_r.ir_scale[B_THIRD_SCL_ON] && third_count_tick_out);
	c_mod_carrier: cover property (carrier_mode_out && port6_bit7_mod_sel_out);
	c_irq: cover property (irq_req_out);
	c_wdt_scaled: cover property (st_r.wdt_mask2[B_WDT_PRESCALE] && wdt_tick_out);

endmodule

// >>> verilog/pcrb_pkg.sv
// package: offsets, field positions and reset values of the peripheral control register bank
package pcrb_pkg;

	localparam int unsigned PCRB_AW = 4;
	localparam int unsigned PCRB_DW = 8;

	// register offsets on the plain register port
	localparam logic [PCRB_AW-1:0] OFS_AUX_BC = 4'h0;
	localparam logic [PCRB_AW-1:0] OFS_IR_SCALE = 4'h1;
	localparam logic [PCRB_AW-1:0] OFS_PULLDOWN = 4'h2;
	localparam logic [PCRB_AW-1:0] OFS_OPENDRAIN = 4'h3;
	localparam logic [PCRB_AW-1:0] OFS_PULLUP = 4'h4;
	localparam logic [PCRB_AW-1:0] OFS_WDT_MASK2 = 4'h5;
	localparam logic [PCRB_AW-1:0] OFS_IRQ_MASK = 4'h6;
	localparam logic [PCRB_AW-1:0] OFS_IRQ_FLAG = 4'h7;
	localparam logic [PCRB_AW-1:0] OFS_IRQ_FLAG2 = 4'h8;
	localparam logic [PCRB_AW-1:0] OFS_GLOBAL = 4'h9;

	// every control register clears to zero
	localparam logic [PCRB_DW-1:0] REG_RESET = 8'h00;
	localparam logic [PCRB_DW-1:0] CNT_ONE = 8'h01;

	// aux_timer_bc_control fields
	localparam int unsigned B_THIRD_EDGE = 0;
	localparam int unsigned B_THIRD_SRC = 1;
	localparam int unsigned B_THIRD_ON = 2;
	localparam logic [PCRB_DW-1:0] AUX_BC_WMASK = 8'hF7;

	// ir_and_scaler_control fields
	localparam int unsigned B_PIN_FUNC = 0;
	localparam int unsigned B_LONG_PULSE = 1;
	localparam int unsigned B_CARRIER = 2;
	localparam int unsigned B_MOD_ON = 3;
	localparam int unsigned B_THIRD_SCL_LO = 4;
	localparam int unsigned B_THIRD_SCL_HI = 6;
	localparam int unsigned B_THIRD_SCL_ON = 7;

	// watchdog_and_mask_two fields
	localparam int unsigned B_WDT_RATIO_LO = 0;
	localparam int unsigned B_WDT_RATIO_HI = 2;
	localparam int unsigned B_WDT_PRESCALE = 3;
	localparam int unsigned B_CMP_MASK = 4;
	localparam int unsigned B_CONV_MASK = 5;
	localparam int unsigned B_EXT_SEL = 6;
	localparam int unsigned B_WDT_ON = 7;

	// global status register field
	localparam int unsigned B_GIE = 0;

	// divide by 2^(code+1): the scaler wraps when its count equals this value
	function automatic logic [PCRB_DW-1:0] scale_last(input logic [2:0] code);
		logic [PCRB_DW:0] full;
		// widen before adding one, or code 7 would wrap to a shift of zero
		full = 9'h001 << ({1'b0, code} + 4'h1);
		scale_last = full[PCRB_DW-1:0] - CNT_ONE;
	endfunction

endpackage
